// *** afl_pkg.sv ***
// Shared constants and types for the arc flash trip and event logger
package afl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int AFL_ZONES = 4;           // Protection zones
    localparam int AFL_CHANS = 4;           // Sensor channels
    localparam int AFL_NSTAT = 26;          // Status bits that raise events
    localparam int AFL_RECS  = 12;          // Operation records kept
    localparam int AFL_TS_W  = 32;          // Millisecond time stamp width
    localparam int AFL_CNT_W = 16;          // Event counter width
    localparam int AFL_CUR_W = 16;          // Current sample width
    localparam int AFL_SG_W  = 3;           // Setting group 1..8 as 0..7
    localparam int AFL_EV_W  = 5;           // Event code width
    localparam int AFL_NRAW  = 17;          // Pin inputs passing the filter, block on top

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int AFL_CLK_HZ      = 10_000_000;
    localparam int AFL_STAMP_MS    = 1;     // Stamp and processing cycle, ms
    localparam int AFL_MS_CLKS     = AFL_CLK_HZ / 1000 * AFL_STAMP_MS;
    localparam int AFL_BLK_LEAD_MS = 5;     // Block lead ahead of trip delay

    ////////////////////////////////////////////////////////////////////////
    // Status vector field positions
    localparam int ST_TRIP    = 0;
    localparam int ST_BLK     = 4;
    localparam int ST_PH_BLK  = 8;
    localparam int ST_PH_ST   = 9;
    localparam int ST_RES_BLK = 10;
    localparam int ST_RES_ST  = 11;
    localparam int ST_LIGHT   = 12;
    localparam int ST_PRESS   = 16;
    localparam int ST_DI      = 20;
    localparam int ST_SFLT    = 21;
    localparam int ST_IOFLT   = 25;

    ////////////////////////////////////////////////////////////////////////
    // Operation record layout, low field first
    localparam int REC_STAMP = 0;
    localparam int REC_CODE  = REC_STAMP + AFL_TS_W;
    localparam int REC_CUR   = REC_CODE + AFL_EV_W;   // A, B, C, residual
    localparam int REC_SENS  = REC_CUR + 4 * AFL_CUR_W;
    localparam int REC_SG    = REC_SENS + AFL_CHANS;
    localparam int REC_W     = REC_SG + AFL_SG_W;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [AFL_TS_W-1:0]  RST_TIME  = 32'h0000_0000;
    localparam logic [AFL_CNT_W-1:0] RST_COUNT = 16'h0000;

    // Digital input option per zone
    typedef enum logic [1:0] {AFL_DI_OFF, AFL_DI_LIGHT, AFL_DI_CURR} afl_di_mode_t;

endpackage : afl_pkg

// *** afl_tick_div.sv ***
// Clock divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module afl_tick_div
    import afl_pkg::*;
#(
    parameter int DIV = AFL_MS_CLKS        // Clocks per pulse
)(
    input  wire logic mclk,
    input  wire logic rst,
    output logic      tick                 // One-cycle pulse every DIV clocks
);

    logic [31:0] cnt;                      // Down counter
    logic [31:0] next_cnt;
    logic        next_tick;

    // Reload on zero so the pulse period is exactly DIV
    always_comb
    begin
        next_tick = (cnt == 32'h0000_0000);
        next_cnt  = next_tick ? 32'(DIV - 1) : cnt - 32'h0000_0001;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt  <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule : afl_tick_div
`default_nettype wire

// *** afl_rec_mem.sv ***
// Ring store for the most recent operation records
`timescale 1ns/1ps
`default_nettype none
module afl_rec_mem
    import afl_pkg::*;
#(
    parameter int DEPTH = AFL_RECS,
    parameter int W     = REC_W
)(
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         wr_en,       // Store one record
    input  wire logic [W-1:0] wr_data,
    input  wire logic [3:0]   rd_idx,      // 0 is the newest record
    output logic      [W-1:0] rd_data,     // Registered read data
    output logic      [3:0]   fill         // Records held
);

    logic [W-1:0] mem [DEPTH];             // Record array, no reset needed
    logic [3:0]   wr_ptr;
    logic [3:0]   next_wr_ptr;
    logic [3:0]   next_fill;
    logic [4:0]   rd_addr;                 // Newest-relative to slot

    // Pointer wraps so the oldest entry is overwritten when full
    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_fill   = fill;
        if (wr_en)
        begin
            next_wr_ptr = (wr_ptr == 4'(DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
            next_fill   = (fill == 4'(DEPTH)) ? fill : fill + 4'h1;
        end
        rd_addr = 5'(wr_ptr) + 5'(DEPTH - 1) - 5'(rd_idx);
        if (rd_addr >= 5'(DEPTH))
            rd_addr = rd_addr - 5'(DEPTH);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= 4'h0;
            fill   <= 4'h0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            fill   <= next_fill;
        end
    end

    // Array write and registered read
    always_ff @(posedge mclk)
    begin
        if (wr_en)
            mem[wr_ptr] <= wr_data;
        rd_data <= mem[rd_addr[3:0]];
    end

    property p_ptr_wrap;
        @(posedge mclk) disable iff (rst)
        (wr_en && wr_ptr == 4'(DEPTH - 1)) |=> (wr_ptr == 4'h0);
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("ring pointer did not wrap");

endmodule : afl_rec_mem
`default_nettype wire

// *** afl_arc_logger.sv ***
// Four-zone arc flash trip, block, status and event logging core
`timescale 1ns/1ps
`default_nettype none
module afl_arc_logger
    import afl_pkg::*;
#(
    parameter int MS_CLKS = AFL_MS_CLKS    // Clocks per millisecond cycle
)(
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic [AFL_CHANS-1:0]        light_raw,
    input  wire logic [AFL_CHANS-1:0]        press_raw,
    input  wire logic                        di_raw,
    input  wire logic                        ph_start_raw,
    input  wire logic                        res_start_raw,
    input  wire logic [AFL_CHANS-1:0]        sens_fault_raw,
    input  wire logic                        io_fault_raw,
    input  wire logic                        block_raw,
    input  wire logic [AFL_ZONES-1:0]        zone_en,
    input  wire logic [AFL_ZONES-1:0][3:0]   light_en,
    input  wire logic [AFL_ZONES-1:0][3:0]   press_en,
    input  wire logic [AFL_ZONES-1:0]        ph_qual_en,
    input  wire logic [AFL_ZONES-1:0]        res_qual_en,
    input  wire logic [AFL_ZONES-1:0][1:0]   di_mode,
    input  wire logic [AFL_NSTAT-1:0]        store_on,
    input  wire logic [AFL_NSTAT-1:0]        store_off,
    input  wire logic                        count_clr,
    input  wire logic                        time_load,
    input  wire logic [AFL_TS_W-1:0]         time_set,
    input  wire logic [AFL_CUR_W-1:0]        cur_a,
    input  wire logic [AFL_CUR_W-1:0]        cur_b,
    input  wire logic [AFL_CUR_W-1:0]        cur_c,
    input  wire logic [AFL_CUR_W-1:0]        cur_res,
    input  wire logic [AFL_SG_W-1:0]         set_group,
    input  wire logic [3:0]                  rec_rd_idx,
    output logic      [AFL_ZONES-1:0]        zone_trip,
    output logic      [AFL_ZONES-1:0]        zone_blocked,
    output logic      [AFL_NSTAT-1:0]        arc_status,
    output logic                             ev_valid,
    output logic      [AFL_EV_W-1:0]         ev_code,
    output logic                             ev_on,
    output logic      [AFL_TS_W-1:0]         ev_stamp,
    output logic      [AFL_CNT_W-1:0]        ev_count,
    output logic      [REC_W-1:0]            rec_rd_data,
    output logic      [3:0]                  rec_fill
);

    ////////////////////////////////////////////////////////////////////////
    // Millisecond processing cycle

    logic ms_tick;                          // One pulse per processing cycle

    afl_tick_div #(.DIV(MS_CLKS)) u_div (
        .mclk (mclk),
        .rst  (rst),
        .tick (ms_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin input filter: three stages, change taken when stages two and three agree

    logic [AFL_NRAW-1:0] raw;               // Gathered pin inputs
    logic [AFL_NRAW-1:0] s1;                // First stage, read by s2 only
    logic [AFL_NRAW-1:0] s2;
    logic [AFL_NRAW-1:0] s3;
    logic [AFL_NRAW-1:0] filt;              // Accepted levels
    logic [AFL_NRAW-1:0] next_filt;

    assign raw = {block_raw, io_fault_raw, sens_fault_raw, res_start_raw,
                  ph_start_raw, di_raw, press_raw, light_raw};

    genvar gi;
    generate
        for (gi = 0; gi < AFL_NRAW; gi++)
        begin : g_filt
            // Single glitches are ignored at the cost of one clock of latency
            always_comb
            begin
                next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
            end

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    s1[gi]   <= 1'b0;
                    s2[gi]   <= 1'b0;
                    s3[gi]   <= 1'b0;
                    filt[gi] <= 1'b0;
                end
                else
                begin
                    s1[gi]   <= raw[gi];
                    s2[gi]   <= s1[gi];
                    s3[gi]   <= s2[gi];
                    filt[gi] <= next_filt[gi];
                end
            end
        end
    endgenerate

    // Filtered views
    logic [3:0] light_f;
    logic [3:0] press_f;
    logic       di_f;
    logic       ph_f;
    logic       res_f;
    logic [3:0] sflt_f;
    logic       ioflt_f;
    logic       blk_f;

    assign light_f = filt[3:0];
    assign press_f = filt[7:4];
    assign di_f    = filt[8];
    assign ph_f    = filt[9];
    assign res_f   = filt[10];
    assign sflt_f  = filt[14:11];
    assign ioflt_f = filt[14+1];
    assign blk_f   = filt[AFL_NRAW-1];

    ////////////////////////////////////////////////////////////////////////
    // Zone pick-up and trip or block decision

    logic [AFL_ZONES-1:0] pick;             // Live pick-up per zone
    logic [AFL_ZONES-1:0] pick_prev;        // Pick-up at last cycle
    logic [AFL_ZONES-1:0] next_pick_prev;
    logic [AFL_ZONES-1:0] next_trip;
    logic [AFL_ZONES-1:0] next_blocked;
    logic                 blk_smp;          // Block level held for the cycle
    logic                 next_blk_smp;

    // Pick-up terms every clock; trip and block decided only on the cycle pulse
    always_comb
    begin
        logic lh;
        logic ph;
        logic sens;
        logic qual;
        lh = 1'b0;
        ph = 1'b0;
        sens = 1'b0;
        qual = 1'b0;
        next_blk_smp   = ms_tick ? blk_f : blk_smp;
        next_pick_prev = pick_prev;
        next_trip      = zone_trip;
        next_blocked   = zone_blocked;
        for (int z = 0; z < AFL_ZONES; z++)
        begin
            lh = |(light_f & light_en[z]);
            ph = |(press_f & press_en[z]);
            case (afl_di_mode_t'(di_mode[z]))
                AFL_DI_CURR:  sens = di_f & (lh | ph);
                AFL_DI_LIGHT: sens = lh | ph | di_f;
                default:      sens = lh | ph;
            endcase
            // Without any current option the sensors act alone
            qual = (ph_qual_en[z] & ph_f) | (res_qual_en[z] & res_f) |
                   ~(ph_qual_en[z] | res_qual_en[z]);
            pick[z] = zone_en[z] & sens & qual;
            if (ms_tick)
            begin
                next_pick_prev[z] = pick[z];
                if (!pick[z])
                begin
                    next_trip[z]    = 1'b0;
                    next_blocked[z] = 1'b0;
                end
                else if (!pick_prev[z])
                begin
                    // Uses the level caught on this very pulse
                    next_trip[z]    = ~blk_f;
                    next_blocked[z] = blk_f;
                end
            end
        end
    end

    // The blocking source must lead the delay; nothing here waits for it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            blk_smp      <= 1'b0;
            pick_prev    <= '0;
            zone_trip    <= '0;
            zone_blocked <= '0;
        end
        else
        begin
            blk_smp      <= next_blk_smp;
            pick_prev    <= next_pick_prev;
            zone_trip    <= next_trip;
            zone_blocked <= next_blocked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status vector and change detection

    logic [AFL_NSTAT-1:0] stat_now;         // Live status
    logic [AFL_NSTAT-1:0] pend_on;          // Pending ON events
    logic [AFL_NSTAT-1:0] pend_off;         // Pending OFF events
    logic [AFL_NSTAT-1:0] next_pend_on;
    logic [AFL_NSTAT-1:0] next_pend_off;
    logic [AFL_NSTAT-1:0] clr_on;           // Bit taken this cycle
    logic [AFL_NSTAT-1:0] clr_off;

    // Blocked flags use the level held for this cycle, not the live pin
    assign stat_now = {ioflt_f, sflt_f, di_f, press_f, light_f,
                       res_f, res_f & blk_smp, ph_f, ph_f & blk_smp,
                       zone_blocked, zone_trip};

    // One event leaves per clock, lowest bit first, ON before OFF
    logic                 found;
    logic [AFL_EV_W-1:0]  pick_code;
    logic                 pick_on;

    always_comb
    begin
        found     = 1'b0;
        pick_code = '0;
        pick_on   = 1'b0;
        clr_on    = '0;
        clr_off   = '0;
        for (int k = AFL_NSTAT - 1; k >= 0; k--)
        begin
            if (pend_on[k] | pend_off[k])
            begin
                found     = 1'b1;
                pick_code = AFL_EV_W'(k);
                pick_on   = pend_on[k];
            end
        end
        if (found && pick_on)
            clr_on[pick_code] = 1'b1;
        else if (found)
            clr_off[pick_code] = 1'b1;
        // A new edge outranks the clear of the same bit
        next_pend_on  = (pend_on & ~clr_on) | (stat_now & ~arc_status);
        next_pend_off = (pend_off & ~clr_off) | (~stat_now & arc_status);
    end

    ////////////////////////////////////////////////////////////////////////
    // Event output, stamp, counter and records

    logic [AFL_TS_W-1:0]  time_ms;          // Running millisecond stamp
    logic [AFL_TS_W-1:0]  next_time;
    logic [AFL_CNT_W-1:0] next_count;
    logic                 next_ev_valid;
    logic                 rec_wr;           // Zone trip ON taken
    logic [REC_W-1:0]     rec_data;

    always_comb
    begin
        next_time = time_load ? time_set :
                    (ms_tick ? time_ms + 32'h0000_0001 : time_ms);
        next_ev_valid = found & (pick_on ? store_on[pick_code]
                                         : store_off[pick_code]);
        // A clear in the same cycle as an event still keeps that event
        if (count_clr)
            next_count = found ? 16'h0001 : RST_COUNT;
        else
            next_count = ev_count + AFL_CNT_W'(found);
        rec_wr = found & pick_on & (pick_code < AFL_EV_W'(ST_BLK));
        rec_data = {set_group, light_f | press_f, cur_res, cur_c, cur_b,
                    cur_a, pick_code, time_ms};
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pend_on    <= '0;
            pend_off   <= '0;
            arc_status <= '0;
            time_ms    <= RST_TIME;
            ev_count   <= RST_COUNT;
            ev_valid   <= 1'b0;
            ev_code    <= '0;
            ev_on      <= 1'b0;
            ev_stamp   <= RST_TIME;
        end
        else
        begin
            pend_on    <= next_pend_on;
            pend_off   <= next_pend_off;
            arc_status <= stat_now;
            time_ms    <= next_time;
            ev_count   <= next_count;
            ev_valid   <= next_ev_valid;
            ev_code    <= found ? pick_code : ev_code;
            ev_on      <= found ? pick_on : ev_on;
            ev_stamp   <= found ? time_ms : ev_stamp;
        end
    end

    afl_rec_mem #(.DEPTH(AFL_RECS), .W(REC_W)) u_rec (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (rec_wr),
        .wr_data (rec_data),
        .rd_idx  (rec_rd_idx),
        .rd_data (rec_rd_data),
        .fill    (rec_fill)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_blk_hold;
        @(posedge mclk) disable iff (rst)
        !ms_tick |=> $stable(blk_smp);
    endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("block level moved mid cycle");

    property p_new_trip;
        @(posedge mclk) disable iff (rst)
        (ms_tick && pick[0] && !pick_prev[0])
            |=> (zone_trip[0] == !blk_smp) && (zone_blocked[0] == blk_smp);
    endproperty
    a_new_trip: assert property (p_new_trip) else $error("zone 0 decision wrong");

    property p_blocked_no_trip;
        @(posedge mclk) disable iff (rst)
        zone_blocked[0] |-> !zone_trip[0];
    endproperty
    a_blocked_no_trip: assert property (p_blocked_no_trip) else $error("blocked zone tripped");

    property p_light_pick;
        @(posedge mclk) disable iff (rst)
        (zone_en[0] && light_f[0] && light_en[0][0] && di_mode[0] == 2'h0
         && !ph_qual_en[0] && !res_qual_en[0]) |-> pick[0];
    endproperty
    a_light_pick: assert property (p_light_pick) else $error("light did not pick up");

    property p_change_event;
        @(posedge mclk) disable iff (rst)
        (stat_now != arc_status) |=> ((pend_on | pend_off) != '0);
    endproperty
    a_change_event: assert property (p_change_event) else $error("change left no event");

    property p_store_mask;
        @(posedge mclk) disable iff (rst)
        found |=> (ev_valid == (ev_on ? $past(store_on[pick_code])
                                      : $past(store_off[pick_code])));
    endproperty
    a_store_mask: assert property (p_store_mask) else $error("masked event stored");

    property p_stamp;
        @(posedge mclk) disable iff (rst)
        ev_valid |-> (ev_stamp == $past(time_ms));
    endproperty
    a_stamp: assert property (p_stamp) else $error("event stamp wrong");

    property p_count;
        @(posedge mclk) disable iff (rst)
        (found && !count_clr) |=> (ev_count == $past(ev_count) + 16'h0001);
    endproperty
    a_count: assert property (p_count) else $error("event count not advanced");

endmodule : afl_arc_logger
`default_nettype wire

// *** afl_sensor_model.sv ***
// Arc light and pressure sensor channels seen by the logger
`timescale 1ns/1ps
`default_nettype none
module afl_sensor_model
    import afl_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic [AFL_CHANS-1:0] light_req,   // Scene light per channel
    input  wire logic [AFL_CHANS-1:0] press_req,   // Scene pressure per channel
    output logic      [AFL_CHANS-1:0] light_raw,   // Detector outputs
    output logic      [AFL_CHANS-1:0] press_raw
);
    // Detectors answer just after an edge, never on it, to keep races out
    always @(posedge mclk)
    begin
        light_raw <= #1 light_req;
        press_raw <= #1 press_req;
    end
endmodule : afl_sensor_model
`default_nettype wire

// *** afl_arc_logger_tb_top.sv ***
// Self-checking bench for the arc flash trip and event logger
`timescale 1ns/1ps
`default_nettype none
module afl_arc_logger_tb_top;
    import afl_pkg::*;
    localparam int MS = 20;                       // Short ms cycle for the run
    logic mclk, rst, di_raw, ph_start_raw, res_start_raw, io_fault_raw;
    logic block_raw, count_clr, time_load, ev_valid, ev_on;
    logic [3:0] light_req, press_req, light_raw, press_raw, sens_fault_raw;
    logic [3:0] zone_en, ph_qual_en, res_qual_en, rec_rd_idx, rec_fill;
    logic [3:0] zone_trip, zone_blocked;
    logic [AFL_ZONES-1:0][3:0] light_en, press_en;
    logic [AFL_ZONES-1:0][1:0] di_mode;
    logic [AFL_NSTAT-1:0] store_on, store_off, arc_status;
    logic [31:0] time_set, ev_stamp;
    logic [15:0] cur_a, cur_b, cur_c, cur_res, ev_count;
    logic [2:0] set_group;
    logic [4:0] ev_code;
    logic [REC_W-1:0] rec_rd_data;
    int bad_count, checked, cyc;

    afl_sensor_model afl_sensor_model_inst (.mclk, .light_req, .press_req, .light_raw,
        .press_raw);
    afl_arc_logger #(.MS_CLKS(MS)) afl_arc_logger_inst (.mclk, .rst, .light_raw,
        .press_raw, .di_raw, .ph_start_raw, .res_start_raw, .sens_fault_raw, .io_fault_raw,
        .block_raw, .zone_en, .light_en, .press_en, .ph_qual_en, .res_qual_en, .di_mode,
        .store_on, .store_off, .count_clr, .time_load, .time_set, .cur_a, .cur_b, .cur_c,
        .cur_res, .set_group, .rec_rd_idx, .zone_trip, .zone_blocked, .arc_status,
        .ev_valid, .ev_code, .ev_on, .ev_stamp, .ev_count, .rec_rd_data, .rec_fill);

    ////////////////////////////////////////////////////////////////////////
    // Clock and a hang guard well above the planned run length
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic stop_test();
        $display("bad_count %0d checked %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Advance n edges and land just after the last one
    task automatic clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : clk
    // Wait for one given stored event; other events may pass first
    task automatic wait_ev(input logic [4:0] code, input logic on);
        int n;
        n = 0;
        while (!(ev_valid === 1'b1 && ev_code === code && ev_on === on) && n < 200)
        begin
            clk(1);
            n++;
        end
        chk(32'(ev_valid), 32'h1);
        chk(32'(ev_code), 32'(code));
        chk(32'(ev_on), 32'(on));
    endtask : wait_ev

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Light trips zone 0; zone 1 waits for phase current; record contents
    task automatic t_trip();
        {cur_b, cur_c, cur_res} = {16'h00b1, 16'h00c1, 16'h00e1};
        time_set = 32'h0000_1000;
        time_load = 1'b1;
        light_req = 4'h1;
        clk(1);
        time_load = 1'b0;
        wait_ev(5'(ST_TRIP), 1'b1);
        // One or two ms pulses fall between the load and the trip event
        chk(32'(ev_stamp == 32'h0000_1001 || ev_stamp == 32'h0000_1002), 32'h1);
        chk(32'(zone_trip), 32'h1);
        chk(32'(zone_blocked), 32'h0);
        chk(32'(arc_status[ST_LIGHT +: 4]), 32'h1);
        clk(2);
        rec_rd_idx = 4'h0;
        clk(1);
        chk(32'(rec_rd_data[REC_CODE +: AFL_EV_W]), 32'h0);
        chk(rec_rd_data[REC_CUR +: 32], 32'h00b1_0000);
        chk(rec_rd_data[REC_CUR + 32 +: 32], 32'h00e1_00c1);
        chk(32'(rec_rd_data[REC_STAMP +: 32] == 32'h0000_1001
                || rec_rd_data[REC_STAMP +: 32] == 32'h0000_1002), 32'h1);
        chk(32'(rec_rd_data[REC_SENS +: 4]), 32'h1);
        chk(32'(rec_rd_data[REC_SG +: 3]), 32'h5);
        chk(32'(rec_fill), 32'h1);
        light_req = 4'h0;
        wait_ev(5'(ST_TRIP), 1'b0);
        chk(32'(zone_trip), 32'h0);
    endtask : t_trip
    // Phase current start lets zone 1 trip on light
    task automatic t_qual();
        ph_start_raw = 1'b1;
        light_req = 4'h1;
        wait_ev(5'(ST_TRIP + 1), 1'b1);
        chk(32'(zone_trip), 32'h3);
        light_req = 4'h0;
        ph_start_raw = 1'b0;
        wait_ev(5'(ST_TRIP + 1), 1'b0);
    endtask : t_qual
    // Block set ahead of pick-up; dropping block later must not trip
    task automatic t_block();
        block_raw = 1'b1;
        clk(2 * MS);
        light_req = 4'h1;
        wait_ev(5'(ST_BLK), 1'b1);
        chk(32'(zone_trip), 32'h0);
        block_raw = 1'b0;
        clk(3 * MS);
        chk(32'(zone_trip), 32'h0);
        chk(32'(zone_blocked), 32'h1);
        light_req = 4'h0;
        wait_ev(5'(ST_BLK), 1'b0);
    endtask : t_block
    // Current-in mode: zone 2 needs the digital input together with its channel
    task automatic t_di();
        zone_en[2] = 1'b1;
        light_en[2] = 4'h2;
        di_mode[2] = 2'h2;
        light_req = 4'h2;
        clk(3 * MS);
        chk(32'(zone_trip), 32'h0);
        di_raw = 1'b1;
        sens_fault_raw = 4'h8;
        io_fault_raw = 1'b1;
        wait_ev(5'(ST_TRIP + 2), 1'b1);
        chk(32'(zone_trip), 32'h4);
        chk(32'(arc_status[ST_DI]), 32'h1);
        chk(32'(arc_status[ST_SFLT +: 5]), 32'h18);
        {light_req, di_raw, sens_fault_raw, io_fault_raw} = '0;
        wait_ev(5'(ST_TRIP + 2), 1'b0);
        chk(32'(zone_trip), 32'h0);
    endtask : t_di
    // Counter clear, then a masked ON that still counts
    task automatic t_count();
        logic seen;
        seen = 1'b0;
        // Let events still queued from earlier scenarios drain first
        clk(MS);
        count_clr = 1'b1;
        clk(1);
        count_clr = 1'b0;
        chk(32'(ev_count), 32'h0);
        store_on[ST_PRESS + 2] = 1'b0;
        press_req = 4'h4;
        repeat (12)
        begin
            clk(1);
            seen = seen | ev_valid;
        end
        chk(32'(seen), 32'h0);
        chk(32'(ev_count), 32'h1);
        press_req = 4'h0;
        wait_ev(5'(ST_PRESS + 2), 1'b0);
        chk(32'(ev_count), 32'h2);
    endtask : t_count
    // Thirteen trips: the store keeps the newest twelve
    task automatic t_ring();
        for (int i = 0; i < 13; i++)
        begin
            cur_a = 16'(i);
            light_req = 4'h1;
            wait_ev(5'(ST_TRIP), 1'b1);
            light_req = 4'h0;
            wait_ev(5'(ST_TRIP), 1'b0);
        end
        clk(2);
        chk(32'(rec_fill), 32'hc);
        rec_rd_idx = 4'hb;
        clk(1);
        chk(32'(rec_rd_data[REC_CUR +: 16]), 32'h1);
        rec_rd_idx = 4'h0;
        clk(1);
        chk(32'(rec_rd_data[REC_CUR +: 16]), 32'hc);
    endtask : t_ring

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: zone 0 light only, zone 1 light with phase current
    initial
    begin
        {light_req, press_req, di_raw, ph_start_raw, res_start_raw} = '0;
        {sens_fault_raw, io_fault_raw, block_raw, count_clr, time_load} = '0;
        {ph_qual_en, res_qual_en, press_en, di_mode, rec_rd_idx} = '0;
        {time_set, cur_a, cur_b, cur_c, cur_res} = '0;
        zone_en = 4'h3;
        light_en = '0;
        light_en[0] = 4'h1;
        light_en[1] = 4'h1;
        ph_qual_en[1] = 1'b1;
        store_on = '1;
        store_off = '1;
        set_group = 3'h5;
        bad_count = 0;
        checked = 0;
        cyc = 0;
        rst = 1'b1;
        clk(3);
        rst = 1'b0;
        clk(MS);
        t_trip();
        t_qual();
        t_block();
        t_di();
        t_count();
        t_ring();
        stop_test();
    end
endmodule : afl_arc_logger_tb_top
`default_nettype wire
